// file: prot_alarm_pkg.sv
// Package with register offsets, field positions, reset values and timing constants
// for the protection alarm and voting block.
// Assumes a 125 MHz monitor clock and a word-aligned Avalon-MM register space.
package prot_alarm_pkg;
  localparam int CLK_MHZ = 125;
  localparam int ADDR_W = 8;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MULT = 8'h04;
  localparam logic [7:0] OFS_ACCESS = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_TEMPMAX = 8'h14;
  localparam logic [7:0] OFS_PEAK = 8'h18;
  localparam logic [7:0] OFS_ALERTSP = 8'h1c;
  localparam logic [7:0] OFS_DANGERSP = 8'h20;
  localparam logic [7:0] OFS_TEMPSP = 8'h24;
  localparam logic [7:0] OFS_DELAY = 8'h28;
  localparam logic [7:0] OFS_SPEED = 8'h2c;
  // Control register fields.
  localparam int CTRL_W = 5;
  localparam int CB_VIBDUAL = 0;
  localparam int CB_TEMPPAIR = 1;
  localparam int CB_UPSCALE = 2;
  localparam int CB_UNITF = 3;
  localparam int CB_MAGNETIC = 4;
  // Command register fields.
  localparam int CMD_PEAKCLR = 8;
  // Status register fields.
  localparam int ST_MULT = 8;
  localparam int ST_TEMPFLT = 9;
  localparam int ST_VIBDNG = 10;
  localparam int ST_TEMPDNG = 11;
  localparam int ST_UNLOCK = 12;
  localparam int ST_ALERT = 16;
  // Multiplier factors.
  localparam logic [1:0] MULT_X2 = 2'h2;
  localparam logic [1:0] MULT_X3 = 2'h3;
  localparam logic [1:0] MULT_RST = MULT_X3;
  // Value written to the access register that opens one protected write.
  localparam logic [31:0] ACCESS_KEY = 32'h0000a5c3;
  // Setpoint and delay reset values.
  localparam logic [15:0] ALERTSP_RST = 16'hffff;
  localparam logic [15:0] DANGERSP_RST = 16'hffff;
  localparam logic [15:0] DELAY_RST = 16'h0001;
  // Temperature: one degree per count, full scale covers 1023 degrees.
  localparam int TEMP_W = 10;
  localparam logic [TEMP_W-1:0] TEMP_ZERO = 10'h000;
  localparam logic [TEMP_W-1:0] TEMP_FULL = 10'h3ff;
  localparam logic [TEMP_W-1:0] TEMPSP_RST = 10'h3ff;
  // Tachometer gate time in milliseconds.
  localparam int GATE_MS = 1000;
  localparam int GATE_CYCLES = GATE_MS * 1000 * CLK_MHZ;
endpackage

// file: protection_alarm_voting.sv
// Alarm, voting and supervision logic: casing vibration fault latching and voting,
// setpoint multiplier, temperature voting and maximum, peak speed hold.
// Assumes all inputs are synchronous to mclk and measurement strobes last one cycle.
// How it works
// RQ1: Open or short on a vibration channel input raises that channel's fault.
// RQ2: Fault latches, blocks the channel, clears only when gone and channel reset.
// RQ3: Multiplier factor write needs the access key written immediately before.
// RQ4: Closed multiplier contact scales alert and danger setpoints by two or three.
// RQ5: Multiplier factor resets to three.
// RQ6: Lamp output is driven while the multiplier is active.
// RQ7: Amplitude outputs pass the measured value unchanged; only thresholds move.
// RQ8: Vibration danger combines channels by dual voting or by OR, selectable.
// RQ9: Any temperature monitor or sensor fault raises the circuit-fault status alarm.
// RQ10: Faulted temperature channel reads zero unless upscale failing is chosen.
// RQ11: Temperatures are whole degrees, C or F, span at least 0 to 150 C.
// RQ12: All temperatures are shown and the highest one is picked automatically.
// RQ13: Single mode: temperature danger when any sensor reaches its setpoint.
// RQ14: Pair mode: danger only when both sensors of a pair reach it.
// RQ15: Pair voting is default with load-zone pair fitted, OR otherwise.
// RQ16: Peak speed is held and raised whenever a measured speed exceeds it.
// RQ17: Peak clear comes from a keyed local input or a keyed remote command.
// RQ18: Speed pulses come from a proximity probe or a magnetic sensor, selectable.
// RQ19: Dual voting danger needs both channels over setpoint for the whole delay.
// RQ20: Comparisons run on each measurement strobe; reset clears alarm outputs.
// RQ21: A latched faulted channel gives no danger vote.
`timescale 1ns/1ns
module protection_alarm_voting #(
  parameter int NVIB = 2,
  parameter int NTEMP = 4,
  parameter int AMP_W = 16,
  parameter bit LOAD_ZONE_PAIR = 1'b1,
  parameter int GATE_CYCLES = prot_alarm_pkg::GATE_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [prot_alarm_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic vibValid,
  input wire logic [NVIB*AMP_W-1:0] vibAmp,
  input wire logic [NVIB-1:0] vibOpen,
  input wire logic [NVIB-1:0] vibShort,
  output logic [NVIB*AMP_W-1:0] vibAmpOut,
  output logic [NVIB-1:0] vibAlert,
  output logic [NVIB-1:0] vibFault,
  output logic vibDanger,
  input wire logic multContact,
  output logic multLamp,
  input wire logic tempValid,
  input wire logic [NTEMP*prot_alarm_pkg::TEMP_W-1:0] tempIn,
  input wire logic [NTEMP-1:0] tempSensorFault,
  input wire logic tempMonitorFault,
  output logic [NTEMP*prot_alarm_pkg::TEMP_W-1:0] tempShown,
  output logic [prot_alarm_pkg::TEMP_W-1:0] tempMax,
  output logic tempUnitF,
  output logic tempFaultAlarm,
  output logic tempDanger,
  input wire logic proxPulse,
  input wire logic magPulse,
  input wire logic localPeakClr,
  input wire logic localKeyOn,
  output logic [15:0] speed,
  output logic [15:0] peakSpeed
);
  localparam int TW = prot_alarm_pkg::TEMP_W;
  // Two spare bits keep a tripled full-scale setpoint from wrapping round.
  localparam int THR_W = AMP_W + 2;

  typedef struct packed {
    logic ack;
    logic [31:0] rdData;
    logic unlock;
    logic [prot_alarm_pkg::CTRL_W-1:0] ctrl;
    logic [1:0] mult;
    logic [15:0] alertSp;
    logic [15:0] dangerSp;
    logic [TW-1:0] tempSp;
    logic [15:0] delay;
    logic [NVIB-1:0] vibFault;
    logic [NVIB-1:0] vibAlert;
    logic [NVIB-1:0] vibOver;
    logic [15:0] dangerCnt;
    logic vibDanger;
    logic [NVIB*AMP_W-1:0] ampOut;
    logic multLamp;
    logic tempFaultAlarm;
    logic tempDanger;
    logic [TW-1:0] tempMax;
    logic [NTEMP*TW-1:0] tempShown;
    logic prevPulse;
    logic [31:0] gateCnt;
    logic [15:0] pulseCnt;
    logic [15:0] speed;
    logic [15:0] peak;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    logic take;
    logic [31:0] wv;
    logic [31:0] rv;
    logic [THR_W-1:0] alertThr;
    logic [THR_W-1:0] dangerThr;
    logic [THR_W-1:0] amp;
    logic healthy;
    logic cond;
    logic anyOver;
    logic allOver;
    logic [TW-1:0] tv;
    logic [TW-1:0] mx;
    logic tAny;
    logic tPair;
    logic pulse;
    logic peakClr;
    logic rise;
    logic [NVIB-1:0] chRst;
    take = 1'b0;
    wv = 32'h00000000;
    rv = 32'h00000000;
    alertThr = '0;
    dangerThr = '0;
    amp = '0;
    healthy = 1'b0;
    cond = 1'b0;
    anyOver = 1'b0;
    allOver = 1'b1;
    tv = prot_alarm_pkg::TEMP_ZERO;
    mx = prot_alarm_pkg::TEMP_ZERO;
    tAny = 1'b0;
    tPair = 1'b0;
    pulse = 1'b0;
    peakClr = 1'b0;
    rise = 1'b0;
    chRst = '0;
    nxt_st = st_ff;

    // Bus answer: the request is acknowledged one cycle after it is seen and acted on
    // at the edge where the master samples waitrequest low.
    take = (read || write) && st_ff.ack;
    nxt_st.ack = (read || write) && !st_ff.ack;
    if (take && write) begin
      // The key opens one write only; any write closes it again, so a stray key
      // cannot leave the protected settings open.
      nxt_st.unlock = 1'b0;
      case (address)
        prot_alarm_pkg::OFS_CTRL: begin
          wv = merge({27'h0, st_ff.ctrl}, writedata, byteenable);
          nxt_st.ctrl = wv[prot_alarm_pkg::CTRL_W-1:0];
        end
        prot_alarm_pkg::OFS_MULT: begin
          wv = merge({30'h0, st_ff.mult}, writedata, byteenable);
          // Only the two legal factors are accepted, and only right after the key.
          if (st_ff.unlock && (wv[1:0] == prot_alarm_pkg::MULT_X2 ||
                               wv[1:0] == prot_alarm_pkg::MULT_X3)) begin
            nxt_st.mult = wv[1:0]; // RQ3
          end
        end
        prot_alarm_pkg::OFS_ACCESS: begin
          nxt_st.unlock = (writedata == prot_alarm_pkg::ACCESS_KEY) && (byteenable == 4'hf);
        end
        prot_alarm_pkg::OFS_CMD: begin
          wv = merge(32'h00000000, writedata, byteenable);
          chRst = wv[NVIB-1:0];
          peakClr = wv[prot_alarm_pkg::CMD_PEAKCLR] && st_ff.unlock; // RQ17
        end
        prot_alarm_pkg::OFS_ALERTSP: begin
          wv = merge({16'h0, st_ff.alertSp}, writedata, byteenable);
          nxt_st.alertSp = wv[15:0];
        end
        prot_alarm_pkg::OFS_DANGERSP: begin
          wv = merge({16'h0, st_ff.dangerSp}, writedata, byteenable);
          nxt_st.dangerSp = wv[15:0];
        end
        prot_alarm_pkg::OFS_TEMPSP: begin
          wv = merge({22'h0, st_ff.tempSp}, writedata, byteenable);
          nxt_st.tempSp = wv[TW-1:0];
        end
        prot_alarm_pkg::OFS_DELAY: begin
          wv = merge({16'h0, st_ff.delay}, writedata, byteenable);
          nxt_st.delay = wv[15:0];
        end
        default: begin
        end
      endcase
    end
    if (nxt_st.ack && read) begin
      case (address)
        prot_alarm_pkg::OFS_CTRL: rv = {27'h0, st_ff.ctrl};
        prot_alarm_pkg::OFS_MULT: rv = {30'h0, st_ff.mult};
        prot_alarm_pkg::OFS_STATUS: begin
          rv[NVIB-1:0] = st_ff.vibFault;
          rv[prot_alarm_pkg::ST_MULT] = st_ff.multLamp;
          rv[prot_alarm_pkg::ST_TEMPFLT] = st_ff.tempFaultAlarm;
          rv[prot_alarm_pkg::ST_VIBDNG] = st_ff.vibDanger;
          rv[prot_alarm_pkg::ST_TEMPDNG] = st_ff.tempDanger;
          rv[prot_alarm_pkg::ST_UNLOCK] = st_ff.unlock;
          rv[prot_alarm_pkg::ST_ALERT +: NVIB] = st_ff.vibAlert;
        end
        prot_alarm_pkg::OFS_TEMPMAX: rv = {22'h0, st_ff.tempMax};
        prot_alarm_pkg::OFS_PEAK: rv = {16'h0, st_ff.peak};
        prot_alarm_pkg::OFS_ALERTSP: rv = {16'h0, st_ff.alertSp};
        prot_alarm_pkg::OFS_DANGERSP: rv = {16'h0, st_ff.dangerSp};
        prot_alarm_pkg::OFS_TEMPSP: rv = {22'h0, st_ff.tempSp};
        prot_alarm_pkg::OFS_DELAY: rv = {16'h0, st_ff.delay};
        prot_alarm_pkg::OFS_SPEED: rv = {16'h0, st_ff.speed};
        default: rv = 32'h00000000;
      endcase
      // Read data then stands until the next read answer, so a slow master
      // may still pick it up after waitrequest has risen again.
      nxt_st.rdData = rv;
    end

    // Setpoint multiplier moves only the thresholds; amplitudes pass through as measured.
    nxt_st.multLamp = multContact; // RQ6
    alertThr = multContact ? THR_W'(st_ff.alertSp) * THR_W'(st_ff.mult)
                           : THR_W'(st_ff.alertSp); // RQ4
    dangerThr = multContact ? THR_W'(st_ff.dangerSp) * THR_W'(st_ff.mult)
                            : THR_W'(st_ff.dangerSp); // RQ4

    for (int i = 0; i < NVIB; i++) begin
      // A present fault wins over a channel reset in the same cycle.
      if (vibOpen[i] || vibShort[i]) begin
        nxt_st.vibFault[i] = 1'b1; // RQ1
      end else if (chRst[i]) begin
        nxt_st.vibFault[i] = 1'b0; // RQ2
      end
      // The fault decided in this cycle already gates the compares, so a channel
      // that latches never shows an alert or casts a vote.
      healthy = !nxt_st.vibFault[i];
      if (vibValid) begin
        amp = THR_W'(vibAmp[i*AMP_W +: AMP_W]);
        nxt_st.ampOut[i*AMP_W +: AMP_W] = vibAmp[i*AMP_W +: AMP_W]; // RQ7
        nxt_st.vibAlert[i] = healthy && (amp >= alertThr); // RQ20
        nxt_st.vibOver[i] = healthy && (amp >= dangerThr); // RQ21
      end else if (!healthy) begin
        nxt_st.vibAlert[i] = 1'b0; // RQ2
        nxt_st.vibOver[i] = 1'b0; // RQ21
      end
      anyOver = anyOver || nxt_st.vibOver[i];
      allOver = allOver && nxt_st.vibOver[i];
    end
    cond = st_ff.ctrl[prot_alarm_pkg::CB_VIBDUAL] ? allOver : anyOver; // RQ8
    // The condition must hold without a break for the delay; any gap restarts the count.
    if (!cond) begin
      nxt_st.dangerCnt = 16'h0000; // RQ19
      nxt_st.vibDanger = 1'b0;
    end else if (st_ff.dangerCnt >= st_ff.delay) begin
      nxt_st.vibDanger = 1'b1; // RQ19
    end else begin
      nxt_st.dangerCnt = st_ff.dangerCnt + 16'h0001;
    end

    // Temperature: downscale failing keeps a dead sensor from casting a vote unless the setpoint is zero.
    nxt_st.tempFaultAlarm = tempMonitorFault || (|tempSensorFault); // RQ9
    if (tempValid) begin
      for (int t = 0; t < NTEMP; t++) begin
        if (tempSensorFault[t] || tempMonitorFault) begin
          tv = st_ff.ctrl[prot_alarm_pkg::CB_UPSCALE] ? prot_alarm_pkg::TEMP_FULL
                                                      : prot_alarm_pkg::TEMP_ZERO; // RQ10
        end else begin
          tv = tempIn[t*TW +: TW]; // RQ11
        end
        nxt_st.tempShown[t*TW +: TW] = tv; // RQ12
        if (tv > mx) begin
          mx = tv; // RQ12
        end
        tAny = tAny || (tv >= st_ff.tempSp); // RQ13
        // Pairs are neighbouring sensors; an odd last sensor votes in single mode only.
        if (t % 2 == 1) begin
          tPair = tPair || ((tv >= st_ff.tempSp) &&
                            (nxt_st.tempShown[(t-1)*TW +: TW] >= st_ff.tempSp)); // RQ14
        end
      end
      nxt_st.tempMax = mx;
      nxt_st.tempDanger = st_ff.ctrl[prot_alarm_pkg::CB_TEMPPAIR] ? tPair : tAny; // RQ14
    end

    // Tachometer: count pulse edges over a gate and keep the highest count.
    // Speed is edges per gate window; scaling to revolutions per minute is left
    // to software, which knows the teeth on the wheel.
    pulse = st_ff.ctrl[prot_alarm_pkg::CB_MAGNETIC] ? magPulse : proxPulse; // RQ18
    nxt_st.prevPulse = pulse;
    rise = pulse && !st_ff.prevPulse;
    if (rise && st_ff.pulseCnt != 16'hffff) begin
      nxt_st.pulseCnt = st_ff.pulseCnt + 16'h0001;
    end
    peakClr = peakClr || (localPeakClr && localKeyOn); // RQ17
    if (st_ff.gateCnt >= 32'(GATE_CYCLES - 1)) begin
      nxt_st.gateCnt = 32'h00000000;
      // An edge on the closing cycle opens the next window, so none is lost.
      nxt_st.pulseCnt = {15'h0000, rise};
      nxt_st.speed = st_ff.pulseCnt;
      if (st_ff.pulseCnt > st_ff.peak) begin
        nxt_st.peak = st_ff.pulseCnt; // RQ16
      end
    end else begin
      nxt_st.gateCnt = st_ff.gateCnt + 32'h00000001;
    end
    // A clear wins over an update in the same cycle, so the held value restarts
    // from zero and the next window alone sets it again.
    if (peakClr) begin
      nxt_st.peak = 16'h0000; // RQ17
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff.ack <= 1'b0;
      st_ff.rdData <= 32'h00000000;
      st_ff.unlock <= 1'b0;
      // Pair voting is the default only where the load-zone pair is fitted.
      st_ff.ctrl <= {4'h0, LOAD_ZONE_PAIR} << prot_alarm_pkg::CB_TEMPPAIR; // RQ15
      st_ff.mult <= prot_alarm_pkg::MULT_RST; // RQ5
      st_ff.alertSp <= prot_alarm_pkg::ALERTSP_RST;
      st_ff.dangerSp <= prot_alarm_pkg::DANGERSP_RST;
      st_ff.tempSp <= prot_alarm_pkg::TEMPSP_RST;
      st_ff.delay <= prot_alarm_pkg::DELAY_RST;
      st_ff.vibFault <= '0;
      st_ff.vibAlert <= '0; // RQ20
      st_ff.vibOver <= '0;
      st_ff.dangerCnt <= 16'h0000;
      st_ff.vibDanger <= 1'b0; // RQ20
      st_ff.ampOut <= '0;
      st_ff.multLamp <= 1'b0;
      st_ff.tempFaultAlarm <= 1'b0;
      st_ff.tempDanger <= 1'b0; // RQ20
      st_ff.tempMax <= prot_alarm_pkg::TEMP_ZERO;
      st_ff.tempShown <= '0;
      st_ff.prevPulse <= 1'b0;
      st_ff.gateCnt <= 32'h00000000;
      st_ff.pulseCnt <= 16'h0000;
      st_ff.speed <= 16'h0000;
      st_ff.peak <= 16'h0000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign readdata = st_ff.rdData;
  assign waitrequest = !st_ff.ack;
  assign vibAmpOut = st_ff.ampOut;
  assign vibAlert = st_ff.vibAlert;
  assign vibFault = st_ff.vibFault;
  assign vibDanger = st_ff.vibDanger;
  assign multLamp = st_ff.multLamp;
  assign tempShown = st_ff.tempShown;
  assign tempMax = st_ff.tempMax;
  // The unit flag only labels the values; nothing is converted, so the setpoint
  // must be written in the same unit as the sensors deliver.
  assign tempUnitF = st_ff.ctrl[prot_alarm_pkg::CB_UNITF]; // RQ11
  assign tempFaultAlarm = st_ff.tempFaultAlarm;
  assign tempDanger = st_ff.tempDanger;
  assign speed = st_ff.speed;
  assign peakSpeed = st_ff.peak;
endmodule

// file: protection_alarm_voting_assertions.sv
// Concurrent checks on the ports of the protection alarm and voting block.
// Assumes one clock domain, mclk, with rst_b as the asynchronous active-low reset.
`timescale 1ns/1ns
module prot_alarm_checker #(
  parameter int NVIB = 2,
  parameter int NTEMP = 4,
  parameter int AMP_W = 16
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [prot_alarm_pkg::ADDR_W-1:0] address,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic vibValid,
  input wire logic [NVIB*AMP_W-1:0] vibAmp,
  input wire logic [NVIB-1:0] vibOpen,
  input wire logic [NVIB-1:0] vibShort,
  input wire logic [NVIB*AMP_W-1:0] vibAmpOut,
  input wire logic [NVIB-1:0] vibAlert,
  input wire logic [NVIB-1:0] vibFault,
  input wire logic vibDanger,
  input wire logic multContact,
  input wire logic multLamp,
  input wire logic [NTEMP-1:0] tempSensorFault,
  input wire logic tempMonitorFault,
  input wire logic tempFaultAlarm,
  input wire logic localPeakClr,
  input wire logic localKeyOn,
  input wire logic [15:0] speed,
  input wire logic [15:0] peakSpeed
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  a_fault_latch: assert property (1'b1 |=> (vibFault & $past(vibOpen | vibShort)) ==
    $past(vibOpen | vibShort)) else $error("open or short did not latch a fault");
  // Only an acted-on write to the command register may release a latched fault.
  a_fault_keep: assert property (!(write && !waitrequest &&
    address == prot_alarm_pkg::OFS_CMD) |=> (vibFault & $past(vibFault)) == $past(vibFault))
    else $error("fault released without channel reset");
  a_fault_noalert: assert property ((vibAlert & vibFault) == '0)
    else $error("faulted channel shows an alert");
  a_both_novote: assert property (&vibFault |=> !vibDanger)
    else $error("danger with all channels faulted");
  a_lamp_follows: assert property (1'b1 |=> multLamp == $past(multContact))
    else $error("lamp does not follow multiplier contact");
  a_amp_unscaled: assert property (vibValid |=> vibAmpOut == $past(vibAmp))
    else $error("amplitude output differs from input");
  a_temp_flt: assert property (1'b1 |=> tempFaultAlarm ==
    $past(tempMonitorFault || (|tempSensorFault))) else $error("temperature fault alarm wrong");
  a_peak_up: assert property (!(localPeakClr && localKeyOn) &&
    !(write && !waitrequest && address == prot_alarm_pkg::OFS_CMD) ##1
    ($changed(speed) && speed > $past(peakSpeed)) |-> peakSpeed == speed)
    else $error("peak did not follow a higher speed");
  a_peak_clr: assert property (localPeakClr && localKeyOn |=> peakSpeed == 16'h0)
    else $error("keyed local clear ignored");
  cover property ($rose(vibDanger));
  cover property (vibFault != '0);
  cover property (localPeakClr && localKeyOn);
  cover property ($rose(multLamp));
endmodule
bind protection_alarm_voting prot_alarm_checker #(.NVIB(NVIB), .NTEMP(NTEMP), .AMP_W(AMP_W))
  prot_alarm_checker_i (.mclk, .rst_b, .address, .write, .waitrequest, .vibValid, .vibAmp,
  .vibOpen, .vibShort, .vibAmpOut, .vibAlert, .vibFault, .vibDanger, .multContact, .multLamp,
  .tempSensorFault, .tempMonitorFault, .tempFaultAlarm, .localPeakClr, .localKeyOn, .speed,
  .peakSpeed);

// file: speed_transducer_model.sv
// Stand-in for the speed transducers: a proximity probe and a magnetic sensor.
// Assumes the bench raises run only while speed is measured; both lines idle low.
`timescale 1ns/1ns
module speed_transducer_model #(
  parameter int PROX_HALF = 25,
  parameter int MAG_HALF = 5
) (
  input wire logic mclk,
  input wire logic run,
  output logic proxPulse,
  output logic magPulse
);
  int pc = 0;
  int mc = 0;
  // Both sensors run together at different rates, so a wrong selection shows in the count.
  always @(posedge mclk) begin
    if (!run) begin
      proxPulse <= 1'b0;
      magPulse <= 1'b0;
      pc <= 0;
      mc <= 0;
    end else begin
      pc <= (pc == PROX_HALF - 1) ? 0 : pc + 1;
      mc <= (mc == MAG_HALF - 1) ? 0 : mc + 1;
      if (pc == PROX_HALF - 1) proxPulse <= !proxPulse;
      if (mc == MAG_HALF - 1) magPulse <= !magPulse;
    end
  end
endmodule

// file: test_protection_alarm_voting.sv
// Self-checking bench for the protection alarm and voting block.
// Assumes a 50-cycle speed gate, two vibration channels and four temperature sensors.
`timescale 1ns/1ns
module test_protection_alarm_voting;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata, rdv;
  logic waitrequest, vibDanger, multLamp, tempUnitF, tempFaultAlarm, tempDanger;
  logic vibValid = 1'b0, multContact = 1'b0, tempValid = 1'b0, tempMonitorFault = 1'b0;
  logic localPeakClr = 1'b0, localKeyOn = 1'b0, run = 1'b0, proxPulse, magPulse;
  logic [31:0] vibAmp = 32'h0, vibAmpOut;
  logic [1:0] vibOpen = 2'h0, vibShort = 2'h0, vibAlert, vibFault;
  logic [39:0] tempIn = 40'h0, tempShown;
  logic [3:0] tempSensorFault = 4'h0;
  logic [9:0] tempMax;
  logic [15:0] speed, peakSpeed;
  int err_total = 0;
  int tests_run = 0;
  localparam logic [39:0] TBASE = {10'h03c, 10'h06e, 10'h032, 10'h078};
  protection_alarm_voting #(.GATE_CYCLES(50)) protection_alarm_voting_i (.mclk, .rst_b,
    .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .vibValid,
    .vibAmp, .vibOpen, .vibShort, .vibAmpOut, .vibAlert, .vibFault, .vibDanger, .multContact,
    .multLamp, .tempValid, .tempIn, .tempSensorFault, .tempMonitorFault, .tempShown, .tempMax,
    .tempUnitF, .tempFaultAlarm, .tempDanger, .proxPulse, .magPulse, .localPeakClr,
    .localKeyOn, .speed, .peakSpeed);
  speed_transducer_model speed_transducer_model_i (.mclk, .run, .proxPulse, .magPulse);
  always #4 mclk = !mclk;
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    address <= a;
    read <= 1'b1;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic vp(input logic [31:0] a);
    @(posedge mclk);
    vibAmp <= a;
    vibValid <= 1'b1;
    @(posedge mclk);
    vibValid <= 1'b0;
    hold(2);
  endtask
  task automatic tp(input logic [39:0] t);
    @(posedge mclk);
    tempIn <= t;
    tempValid <= 1'b1;
    @(posedge mclk);
    tempValid <= 1'b0;
    hold(2);
  endtask
  task automatic t_regs();
    rd(prot_alarm_pkg::OFS_CTRL, rdv);
    chk(rdv, 32'h2);
    rd(prot_alarm_pkg::OFS_MULT, rdv);
    chk(rdv, 32'h3);
    wr(prot_alarm_pkg::OFS_MULT, 32'h2);
    rd(prot_alarm_pkg::OFS_MULT, rdv);
    chk(rdv, 32'h3);
    rd(8'h3c, rdv);
    chk(rdv, 32'h0);
  endtask
  task automatic t_vib();
    wr(prot_alarm_pkg::OFS_ALERTSP, 32'h64);
    wr(prot_alarm_pkg::OFS_DANGERSP, 32'hc8);
    wr(prot_alarm_pkg::OFS_DELAY, 32'h3);
    @(posedge mclk);
    multContact <= 1'b1;
    vp(32'h00fa00fa);
    chk(vibAlert, 2'h0);
    chk(multLamp, 1'b1);
    chk(vibAmpOut, 32'h00fa00fa);
    wr(prot_alarm_pkg::OFS_ACCESS, prot_alarm_pkg::ACCESS_KEY);
    wr(prot_alarm_pkg::OFS_MULT, 32'h2);
    rd(prot_alarm_pkg::OFS_MULT, rdv);
    chk(rdv, 32'h2);
    vp(32'h00fa00fa);
    hold(6);
    chk(vibAlert, 2'h3);
    chk(vibDanger, 1'b0);
    @(posedge mclk);
    multContact <= 1'b0;
    vp(32'h003200fa);
    chk(vibAlert, 2'h1);
    chk(vibDanger, 1'b0);
    hold(6);
    chk(vibDanger, 1'b1);
    wr(prot_alarm_pkg::OFS_CTRL, 32'h3);
    vp(32'h003200fa);
    hold(8);
    chk(vibDanger, 1'b0);
    vp(32'h00fa00fa);
    hold(8);
    chk(vibDanger, 1'b1);
    @(posedge mclk);
    vibOpen <= 2'h1;
    hold(1);
    chk(vibFault, 2'h1);
    chk(vibAlert, 2'h2);
    hold(4);
    chk(vibDanger, 1'b0);
    @(posedge mclk);
    vibOpen <= 2'h0;
    vibShort <= 2'h2;
    hold(2);
    chk(vibFault, 2'h3);
    wr(prot_alarm_pkg::OFS_CMD, 32'h3);
    hold(1);
    chk(vibFault, 2'h2);
    @(posedge mclk);
    vibShort <= 2'h0;
    wr(prot_alarm_pkg::OFS_CMD, 32'h2);
    hold(1);
    chk(vibFault, 2'h0);
  endtask
  task automatic t_temp();
    wr(prot_alarm_pkg::OFS_TEMPSP, 32'h64);
    wr(prot_alarm_pkg::OFS_CTRL, 32'h2);
    tp(TBASE);
    chk(tempShown, TBASE);
    chk(tempMax, 10'h078);
    chk(tempDanger, 1'b0);
    wr(prot_alarm_pkg::OFS_CTRL, 32'h0);
    tp(TBASE);
    chk(tempDanger, 1'b1);
    wr(prot_alarm_pkg::OFS_CTRL, 32'ha);
    tp({10'h03c, 10'h06e, 10'h064, 10'h078});
    chk(tempDanger, 1'b1);
    chk(tempUnitF, 1'b1);
    @(posedge mclk);
    tempSensorFault <= 4'h1;
    tp(TBASE);
    chk(tempShown, {TBASE[39:10], 10'h000});
    chk(tempMax, 10'h06e);
    chk(tempFaultAlarm, 1'b1);
    wr(prot_alarm_pkg::OFS_CTRL, 32'h6);
    tp(TBASE);
    chk(tempMax, 10'h3ff);
    @(posedge mclk);
    tempSensorFault <= 4'h0;
    tempMonitorFault <= 1'b1;
    hold(2);
    chk(tempFaultAlarm, 1'b1);
  endtask
  task automatic t_speed();
    @(posedge mclk);
    run <= 1'b1;
    wr(prot_alarm_pkg::OFS_CTRL, 32'h2);
    hold(120);
    chk(speed, 16'h1);
    wr(prot_alarm_pkg::OFS_CTRL, 32'h12);
    hold(120);
    chk(speed, 16'h5);
    @(posedge mclk);
    localPeakClr <= 1'b1;
    localKeyOn <= 1'b1;
    hold(2);
    chk(peakSpeed, 16'h0);
    @(posedge mclk);
    localPeakClr <= 1'b0;
    hold(120);
    chk(peakSpeed, 16'h5);
    @(posedge mclk);
    localPeakClr <= 1'b1;
    localKeyOn <= 1'b0;
    hold(3);
    chk(peakSpeed, 16'h5);
    // Both lines stand still while the source changes, so no false edge is counted.
    @(posedge mclk);
    localPeakClr <= 1'b0;
    run <= 1'b0;
    wr(prot_alarm_pkg::OFS_CTRL, 32'h2);
    @(posedge mclk);
    run <= 1'b1;
    hold(120);
    wr(prot_alarm_pkg::OFS_CMD, 32'h100);
    hold(120);
    chk(peakSpeed, 16'h5);
    wr(prot_alarm_pkg::OFS_ACCESS, prot_alarm_pkg::ACCESS_KEY);
    wr(prot_alarm_pkg::OFS_CMD, 32'h100);
    hold(120);
    rd(prot_alarm_pkg::OFS_PEAK, rdv);
    chk(rdv, 32'h1);
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    t_regs();
    t_vib();
    t_temp();
    t_speed();
    report_and_stop();
  end
  initial begin
    repeat (8000) @(posedge mclk);
    err_total++;
    report_and_stop();
  end
endmodule
